// [hdl/sma_atomic_alu.v]
// Read-modify-write atomic unit for the shared data memory
// Functional notes
// - Add, subtract, reverse subtract; return old word
// - Wrap increment: zero when old >= operand
// - Wrap decrement: operand when zero or above
// - Signed min/max store chosen, return old
// - Unsigned min/max store chosen, return old
// - AND, OR, XOR, masked OR combine operand
// - Qword store; dual store at offset times 8
// - Wide stride dual store: offset times 512
// - Compare-store: equal comparand writes replacement
// - Float compare-store, NaN never equal, zeros equal
// - Float min/max with NaN handling
// - Single float add, specials handled, old returned
// - Exchange, dual exchange, wide stride exchange
`timescale 1ns/10ps
`default_nettype none
`include "sma_regs.vh"
module sma_atomic_alu (
    // Clock and reset
    input  wire                  clock_in,
    input  wire                  rstn_in,
    // Request from lanes
    input  wire                  req_valid_in,
    input  wire [`SMA_OPW-1:0]   req_opcode_in,
    input  wire [`SMA_BAW-1:0]   req_addr_in,
    input  wire [7:0]            req_first_instruction_offset_in,
    input  wire [7:0]            req_second_instruction_offset_in,
    input  wire [63:0]           req_data0_in,
    input  wire [63:0]           req_data1_in,
    output reg                   req_ready_out,
    // Completion
    output reg                   rsp_valid_out,
    output reg                   rsp_return_out,
    output reg                   rsp_error_out,
    output reg  [63:0]           rsp_data0_out,
    output reg  [63:0]           rsp_data1_out
);
    localparam S_IDLE = 5'h01;
    localparam S_RD0  = 5'h02;
    localparam S_WR0  = 5'h04;
    localparam S_RD1  = 5'h08;
    localparam S_WR1  = 5'h10;

    reg [4:0]           state_reg;
    reg [`SMA_OPW-1:0]  op_reg;
    reg                 rtn_reg;
    reg                 dw_hi_reg;
    reg [`SMA_AW-1:0]   addr0_reg;
    reg [`SMA_AW-1:0]   addr1_reg;
    reg [63:0]          d0_reg;
    reg [63:0]          d1_reg;
    reg [63:0]          old0_reg;
    reg [63:0]          new_word;
    reg                 op_ok;
    wire [63:0]         rd_data;
    wire [`SMA_OPW-1:0] req_base;
    wire                wr_phase;
    wire                dual;
    wire [`SMA_AW-1:0]  qidx;
    wire [`SMA_AW-1:0]  off0_s;
    wire [`SMA_AW-1:0]  off1_s;
    wire                wide;
    // Returning opcodes up to SMA_OP_RTN_LAST share the base operation
    assign req_base = {req_opcode_in[7:6],
        req_opcode_in[`SMA_RTN_BIT] & (req_opcode_in > `SMA_OP_RTN_LAST),
        req_opcode_in[4:0]};
    assign wide     = (req_base == `SMA_OP_WR2ST);
    assign qidx     = req_addr_in[`SMA_BAW-1:`SMA_QW_LSB];
    // Offsets in qwords, or 64 qwords each for the wide form
    assign off0_s = wide ? ({5'h00, req_first_instruction_offset_in} << `SMA_STRIDE_SH)
                         : {5'h00, req_first_instruction_offset_in};
    assign off1_s = wide ? ({5'h00, req_second_instruction_offset_in} << `SMA_STRIDE_SH)
                         : {5'h00, req_second_instruction_offset_in};
    assign dual     = (op_reg == `SMA_OP_WR2) | (op_reg == `SMA_OP_WR2ST);
    assign wr_phase = state_reg[3] | state_reg[4];
    // Float helpers
    function f64_nan;
        input [63:0] x;
        f64_nan = (&x[62:52]) & (|x[51:0]);
    endfunction
    function f64_lt;
        input [63:0] a;
        input [63:0] b;
        begin
            if (~|{a[62:0], b[62:0]})
                f64_lt = 1'b0;
            else if (a[63] != b[63])
                f64_lt = a[63];
            else if (a[63])
                f64_lt = a[62:0] > b[62:0];
            else
                f64_lt = a[62:0] < b[62:0];
        end
    endfunction
    // Round to nearest even, denormals kept, overflow to infinity
    function [31:0] f32_add;
        input [31:0] a;
        input [31:0] b;
        reg   [31:0] x;
        reg   [31:0] y;
        reg   [9:0]  ex;
        reg   [9:0]  ey;
        reg   [9:0]  d;
        reg   [26:0] mx;
        reg   [26:0] my;
        reg   [27:0] s;
        reg   [24:0] m;
        reg          up;
        integer      i;
        begin
            x = (a[30:0] >= b[30:0]) ? a : b;
            y = (a[30:0] >= b[30:0]) ? b : a;
            ex = (x[30:23] == 8'h00) ? 10'h001 : {2'b00, x[30:23]};
            ey = (y[30:23] == 8'h00) ? 10'h001 : {2'b00, y[30:23]};
            mx = {|x[30:23], x[22:0], 3'b000};
            my = {|y[30:23], y[22:0], 3'b000};
            d  = ex - ey;
            if (d >= 10'd27)
                my = {26'h0, |my};
            else
                my = (my >> d) | {26'h0, |(my & ((27'h1 << d) - 27'h1))};
            s = (x[31] == y[31]) ? {1'b0, mx} + {1'b0, my}
                                 : {1'b0, mx} - {1'b0, my};
            if (s[27]) begin
                s  = {1'b0, s[27:2], s[1] | s[0]};
                ex = ex + 10'h001;
            end
            for (i = 0; i < 26; i = i + 1) begin
                if (!s[26] && ex > 10'h001) begin
                    s  = s << 1;
                    ex = ex - 10'h001;
                end
            end
            up = s[2] & (s[1] | s[0] | s[3]);
            m  = {1'b0, s[26:3]} + {24'h0, up};
            if (m[24]) begin
                m  = m >> 1;
                ex = ex + 10'h001;
            end
            if ((&a[30:23] && |a[22:0]) || (&b[30:23] && |b[22:0]))
                f32_add = `SMA_F32_QNAN;
            else if (&a[30:23] && &b[30:23] && a[31] != b[31])
                f32_add = `SMA_F32_QNAN;
            else if (&x[30:23])
                f32_add = x;
            else if (s == 28'h0)
                f32_add = {a[31] & b[31], 31'h0};
            else if (ex >= 10'h0ff)
                f32_add = {x[31], `SMA_F32_INF};
            else
                f32_add = {x[31], (m[23] ? ex[7:0] : 8'h00), m[22:0]};
        end
    endfunction

    // New word from the old one read this cycle
    always @* begin
        op_ok = 1'b1;
        new_word = rd_data;
        if (wr_phase) begin
            new_word = d1_reg;
        end else begin
            case (op_reg)
                `SMA_OP_ADD:    new_word = rd_data + d0_reg;
                `SMA_OP_SUB:    new_word = rd_data - d0_reg;
                `SMA_OP_RSUB:   new_word = d0_reg - rd_data;
                `SMA_OP_INC:    new_word = (rd_data >= d0_reg) ? 64'h0
                                           : rd_data + 64'h1;
                `SMA_OP_DEC:    new_word = (rd_data == 64'h0 ||
                                            rd_data > d0_reg) ? d0_reg
                                           : rd_data - 64'h1;
                `SMA_OP_MINI:   new_word = ($signed(d0_reg) <
                                    $signed(rd_data)) ? d0_reg
                                           : rd_data;
                `SMA_OP_MAXI:   new_word = ($signed(d0_reg) >
                                    $signed(rd_data)) ? d0_reg
                                           : rd_data;
                `SMA_OP_MINU:   new_word = (d0_reg < rd_data) ? d0_reg
                                           : rd_data;
                `SMA_OP_MAXU:   new_word = (d0_reg > rd_data) ? d0_reg
                                           : rd_data;
                `SMA_OP_AND:    new_word = rd_data & d0_reg;
                `SMA_OP_OR:     new_word = rd_data | d0_reg;
                `SMA_OP_XOR:    new_word = rd_data ^ d0_reg;
                `SMA_OP_MSKOR:  new_word = (rd_data & ~d0_reg)
                                           | d1_reg;
                `SMA_OP_WR,
                `SMA_OP_WR2,
                `SMA_OP_WR2ST:  new_word = d0_reg;
                `SMA_OP_CMPST:  new_word = (rd_data == d0_reg) ? d1_reg
                                           : rd_data;
                // NaN never matches; plus and minus zero do
                `SMA_OP_FCMPST: new_word = (!f64_nan(rd_data) &&
                                    !f64_nan(d0_reg) &&
                                    (rd_data == d0_reg ||
                                     ~|{rd_data[62:0], d0_reg[62:0]}))
                                           ? d1_reg : rd_data;
                // A NaN on one side yields the other value
                `SMA_OP_FMIN:   new_word = f64_nan(d0_reg) ? rd_data :
                                    f64_nan(rd_data) ? d0_reg :
                                    f64_lt(d0_reg, rd_data) ? d0_reg
                                           : rd_data;
                `SMA_OP_FMAX:   new_word = f64_nan(d0_reg) ? rd_data :
                                    f64_nan(rd_data) ? d0_reg :
                                    f64_lt(rd_data, d0_reg) ? d0_reg
                                           : rd_data;
                `SMA_OP_FADD32: new_word = dw_hi_reg
                    ? {f32_add(rd_data[63:32], d0_reg[31:0]), rd_data[31:0]}
                    : {rd_data[63:32], f32_add(rd_data[31:0], d0_reg[31:0])};
                default:        op_ok = 1'b0;
            endcase
        end
    end
    sma_qword_mem u_mem (
        .clock_in    (clock_in),
        .addr_in     (wr_phase ? addr1_reg : addr0_reg),
        .wr_en_in    (state_reg[2] | state_reg[4]),
        .wr_data_in  (new_word),
        .rd_data_out (rd_data)
    );
    // Single sequencer; requests held off until the write lands
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg      <= S_IDLE;
            req_ready_out  <= 1'b1;
            rsp_valid_out  <= 1'b0;
            rsp_return_out <= 1'b0;
            rsp_error_out  <= 1'b0;
            rsp_data0_out  <= 64'h0;
            rsp_data1_out  <= 64'h0;
            op_reg         <= 8'h00;
            rtn_reg        <= 1'b0;
            dw_hi_reg      <= 1'b0;
            addr0_reg      <= {`SMA_AW{1'b0}};
            addr1_reg      <= {`SMA_AW{1'b0}};
            d0_reg         <= 64'h0;
            d1_reg         <= 64'h0;
            old0_reg       <= 64'h0;
        end else begin
            rsp_valid_out <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        op_reg    <= req_base;
                        rtn_reg   <= req_opcode_in[`SMA_RTN_BIT] |
                                     (req_opcode_in == `SMA_OP_FADD32);
                        dw_hi_reg <= req_addr_in[`SMA_DW_SEL];
                        addr0_reg <= (req_base == `SMA_OP_WR2 || wide)
                                     ? qidx + off0_s : qidx;
                        addr1_reg <= qidx + off1_s;
                        d0_reg    <= req_data0_in;
                        d1_reg    <= req_data1_in;
                        req_ready_out <= 1'b0;
                        state_reg <= S_RD0;
                    end
                end
                S_RD0: begin
                    state_reg <= S_WR0;
                end
                S_WR0: begin
                    old0_reg <= rd_data;
                    if (op_ok && dual) begin
                        state_reg <= S_RD1;
                    end else begin
                        // Single ops complete here; unknown opcode: old word rewritten, error flagged
                        rsp_valid_out  <= 1'b1;
                        rsp_error_out  <= !op_ok;
                        rsp_return_out <= rtn_reg & op_ok;
                        rsp_data0_out  <= (op_reg == `SMA_OP_FADD32)
                            ? {32'h0, dw_hi_reg ? rd_data[63:32]
                                                : rd_data[31:0]}
                            : rd_data;
                        rsp_data1_out  <= 64'h0;
                        req_ready_out  <= 1'b1;
                        state_reg      <= S_IDLE;
                    end
                end
                S_RD1: begin
                    state_reg <= S_WR1;
                end
                S_WR1: begin
                    rsp_valid_out  <= 1'b1;
                    rsp_error_out  <= 1'b0;
                    rsp_return_out <= rtn_reg;
                    rsp_data0_out  <= old0_reg;
                    rsp_data1_out  <= rd_data;
                    req_ready_out  <= 1'b1;
                    state_reg      <= S_IDLE;
                end
                default: begin
                    req_ready_out <= 1'b1;
                    state_reg     <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [hdl/sma_qword_mem.v]
// Qword-wide shared data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "sma_regs.vh"
module sma_qword_mem (
    // Clock
    input  wire                clock_in,
    // Access
    input  wire [`SMA_AW-1:0]  addr_in,
    input  wire                wr_en_in,
    input  wire [63:0]         wr_data_in,
    output reg  [63:0]         rd_data_out
);
    reg [63:0] mem_reg [0:(1<<`SMA_AW)-1];

    // Read returns the prior contents when also writing
    always @(posedge clock_in) begin
        rd_data_out <= mem_reg[addr_in];
        if (wr_en_in) begin
            mem_reg[addr_in] <= wr_data_in;
        end
    end
endmodule
`default_nettype wire

// [hdl/sma_regs.vh]
// Opcodes, address layout and float constants of the atomic unit
`ifndef SMA_REGS_VH
`define SMA_REGS_VH

// Opcode width and the bit that marks a returning variant
`define SMA_OPW         8
`define SMA_RTN_BIT     5

// Base opcodes; returning variants of 8'h40 to 8'h50 are these plus 8'h20
`define SMA_OP_ADD      8'h40
`define SMA_OP_SUB      8'h41
`define SMA_OP_RSUB     8'h42
`define SMA_OP_INC      8'h43
`define SMA_OP_DEC      8'h44
`define SMA_OP_MINI     8'h45
`define SMA_OP_MAXI     8'h46
`define SMA_OP_MINU     8'h47
`define SMA_OP_MAXU     8'h48
`define SMA_OP_AND      8'h49
`define SMA_OP_OR       8'h4a
`define SMA_OP_XOR      8'h4b
`define SMA_OP_MSKOR    8'h4c
`define SMA_OP_WR       8'h4d
`define SMA_OP_WR2      8'h4e
`define SMA_OP_WR2ST    8'h4f
`define SMA_OP_CMPST    8'h50
`define SMA_OP_FCMPST   8'h51
`define SMA_OP_FMIN     8'h52
`define SMA_OP_FMAX     8'h53
`define SMA_OP_FADD32   8'h55
// Highest returning opcode; returning forms above it are unknown
`define SMA_OP_RTN_LAST 8'h70

// Byte address width, qword index width and position
`define SMA_BAW         16
`define SMA_AW          13
`define SMA_QW_LSB      3
`define SMA_DW_SEL      2
// Wide stride: 64 qwords per offset unit
`define SMA_STRIDE_SH   6

// Float constants
`define SMA_F32_QNAN    32'h7fc00000
`define SMA_F32_INF     31'h7f800000

`endif

// [testbench/sma_alu_checker.sv]
// Port assertions for the atomic unit
`timescale 1ns/10ps
`default_nettype none
module sma_alu_checker (
    // Clock and reset
    input wire logic        clock_in,
    input wire logic        rstn_in,
    // Request
    input wire logic        req_valid_in,
    input wire logic [7:0]  req_opcode_in,
    input wire logic        req_ready_out,
    // Completion
    input wire logic        rsp_valid_out,
    input wire logic        rsp_return_out,
    input wire logic        rsp_error_out,
    input wire logic [63:0] rsp_data0_out,
    input wire logic [63:0] rsp_data1_out
);
    logic [7:0] op_reg;
    wire        take = req_valid_in && req_ready_out;
    function automatic logic is_dual(input logic [7:0] op);
        is_dual = op == 8'h4e || op == 8'h4f || op == 8'h6e || op == 8'h6f;
    endfunction
    function automatic logic is_rtn(input logic [7:0] op);
        is_rtn = (op >= 8'h60 && op <= 8'h70) || op == 8'h55;
    endfunction
    // Opcode held from acceptance; ready stays low so it cannot move
    always @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in)
            op_reg <= 8'h00;
        else if (take)
            op_reg <= req_opcode_in;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    a_single_latency: assert property (take && !is_dual(req_opcode_in)
        |=> !rsp_valid_out[*2] ##1 rsp_valid_out) else $error("single late");
    a_dual_latency: assert property (take && is_dual(req_opcode_in)
        |=> !rsp_valid_out[*4] ##1 rsp_valid_out) else $error("dual late");
    a_busy_single: assert property (take && !is_dual(req_opcode_in)
        |=> !req_ready_out[*2] ##1 req_ready_out) else $error("busy span");
    a_busy_dual: assert property (take && is_dual(req_opcode_in)
        |=> !req_ready_out[*4] ##1 req_ready_out) else $error("dual busy");
    a_return_flag: assert property (rsp_valid_out
        |-> rsp_return_out == is_rtn(op_reg)) else $error("return flag");
    a_error_flag: assert property (rsp_valid_out |-> rsp_error_out ==
        !(op_reg inside {[8'h40:8'h53], 8'h55, [8'h60:8'h70]}))
        else $error("error flag");
    a_pulse_once: assert property (rsp_valid_out |=> !rsp_valid_out)
        else $error("valid too long");
    a_data_hold: assert property (!rsp_valid_out |-> $stable(rsp_data0_out)
        && $stable(rsp_data1_out)) else $error("data moved");
    a_single_data1: assert property (rsp_valid_out && !is_dual(op_reg)
        |-> rsp_data1_out == 64'h0) else $error("data1 not zero");
    a_f32_upper: assert property (rsp_valid_out && op_reg == 8'h55
        |-> rsp_data0_out[63:32] == 32'h0) else $error("f32 upper");
endmodule
bind sma_atomic_alu sma_alu_checker i_chk (.clock_in(clock_in),
    .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_opcode_in(req_opcode_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_return_out(rsp_return_out),
    .rsp_error_out(rsp_error_out), .rsp_data0_out(rsp_data0_out),
    .rsp_data1_out(rsp_data1_out));
`default_nettype wire

// [testbench/sma_lane_model.sv]
// Shader lane model issuing requests to the atomic unit
`timescale 1ns/10ps
`default_nettype none
module sma_lane_model (
    // Clock
    input  wire logic        clock_in,
    // Request
    output var  logic        req_valid_out,
    output var  logic [7:0]  req_opcode_out,
    output var  logic [15:0] req_addr_out,
    output var  logic [7:0]  req_first_instruction_offset_out,
    output var  logic [7:0]  req_second_instruction_offset_out,
    output var  logic [63:0] req_data0_out,
    output var  logic [63:0] req_data1_out,
    input  wire logic        req_ready_in,
    // Completion
    input  wire logic        rsp_valid_in,
    input  wire logic        rsp_return_in,
    input  wire logic        rsp_error_in,
    input  wire logic [63:0] rsp_data0_in,
    input  wire logic [63:0] rsp_data1_in
);
    logic [63:0] got0;
    logic [63:0] got1;
    logic [1:0]  got_flags;
    initial begin
        {req_valid_out, req_opcode_out, req_addr_out} = '0;
        {req_first_instruction_offset_out, req_second_instruction_offset_out} = '0;
        {req_data0_out, req_data1_out} = '0;
    end
    task issue(input logic [7:0] op, input logic [15:0] ad,
               input logic [7:0] o0, o1, input logic [63:0] a, b);
        int n;
        begin
            @(posedge clock_in);
            #1;
            req_valid_out = 1'b1;
            {req_opcode_out, req_addr_out} = {op, ad};
            {req_first_instruction_offset_out, req_second_instruction_offset_out} = {o0, o1};
            {req_data0_out, req_data1_out} = {a, b};
            n = 0;
            @(posedge clock_in);
            while (req_ready_in !== 1'b1 && n < 20) begin
                n++;
                @(posedge clock_in);
            end
            #1;
            // Released address and data lines toggle so stale values cannot pass
            req_valid_out = 1'b0;
            {req_addr_out, req_data0_out, req_data1_out} = ~{ad, a, b};
            while (rsp_valid_in !== 1'b1 && n < 40) begin
                n++;
                @(posedge clock_in);
                #1;
            end
            got0 = (n < 40) ? rsp_data0_in : 'x;
            got1 = rsp_data1_in;
            got_flags = {rsp_return_in, rsp_error_in};
        end
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking testbench for the atomic unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clock_in = 1'b0;
    logic        rstn_in = 1'b0;
    wire         rv, rr, sv, sr, se;
    wire  [7:0]  op, o0, o1;
    wire  [15:0] ad;
    wire  [63:0] d0, d1, q0, q1;
    int          failures = 0;
    int          n_compared = 0;
    logic [63:0] tv_old [3] = '{64'h5, '1, 64'h0};
    logic [63:0] tv_a [3] = '{64'h5, 64'h1, 64'h3};
    logic [63:0] tv_b [3] = '{64'h9, 64'h7, 64'hf0};
    sma_atomic_alu i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .req_valid_in(rv), .req_opcode_in(op), .req_addr_in(ad),
        .req_first_instruction_offset_in(o0), .req_second_instruction_offset_in(o1), .req_data0_in(d0),
        .req_data1_in(d1), .req_ready_out(rr), .rsp_valid_out(sv),
        .rsp_return_out(sr), .rsp_error_out(se), .rsp_data0_out(q0),
        .rsp_data1_out(q1));
    sma_lane_model i_lane (.clock_in(clock_in), .req_valid_out(rv),
        .req_opcode_out(op), .req_addr_out(ad), .req_first_instruction_offset_out(o0),
        .req_second_instruction_offset_out(o1), .req_data0_out(d0), .req_data1_out(d1),
        .req_ready_in(rr), .rsp_valid_in(sv), .rsp_return_in(sr),
        .rsp_error_in(se), .rsp_data0_in(q0), .rsp_data1_in(q1));
    always #20 clock_in = ~clock_in;
    task chk(input string what, input logic [63:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [63:0] ref_op(input logic [7:0] c,
                                           input logic [63:0] t, a, b);
        case (c & 8'hdf)
            8'h40: ref_op = t + a;
            8'h41: ref_op = t - a;
            8'h42: ref_op = a - t;
            8'h43: ref_op = (t >= a) ? 64'h0 : t + 1;
            8'h44: ref_op = (t == 0 || t > a) ? a : t - 1;
            8'h45: ref_op = ($signed(a) < $signed(t)) ? a : t;
            8'h46: ref_op = ($signed(a) > $signed(t)) ? a : t;
            8'h47: ref_op = (a < t) ? a : t;
            8'h48: ref_op = (a > t) ? a : t;
            8'h49: ref_op = t & a;
            8'h4a: ref_op = t | a;
            8'h4b: ref_op = t ^ a;
            8'h4c: ref_op = (t & ~a) | b;
            8'h4d: ref_op = a;
            8'h50: ref_op = (t == a) ? b : t;
            default: ref_op = t;
        endcase
    endfunction
    task peek(input logic [15:0] a, input logic [63:0] exp);
        i_lane.issue(8'h60, a, 8'h00, 8'h00, 64'h0, 64'h0);
        chk("stored word", exp, i_lane.got0);
    endtask
    task atom(input logic [7:0] c, input logic [63:0] old, a, b, expv);
        logic [63:0] r0x;
        begin
            i_lane.issue(8'h4d, 16'h0104, 8'h00, 8'h00, old, 64'h0);
            i_lane.issue(c, 16'h0104, 8'h03, 8'h05, a, b);
            r0x = (c == 8'h55) ? {32'h0, old[63:32]} : old;
            chk("old word", r0x, i_lane.got0);
            chk("flags", {62'h0, c > 8'h5f && c < 8'h71 || c == 8'h55,
                c == 8'h54 || c == 8'h71}, {62'h0, i_lane.got_flags});
            peek(16'h0104, expv);
        end
    endtask
    task t_alu;
        for (int c = 64; c < 113; c++)
            if (c <= 80 && c != 78 && c != 79 || c >= 96 && c != 110 && c != 111)
                for (int k = 0; k < 3; k++)
                    atom(c[7:0], tv_old[k], tv_a[k], tv_b[k],
                         ref_op(c[7:0], tv_old[k], tv_a[k], tv_b[k]));
        $display("test integer ops done");
    endtask
    task t_dual;
        logic [7:0]  c;
        logic [15:0] a0, a1;
        for (int i = 0; i < 4; i++) begin
            c = (i < 2) ? 8'h4e + i : 8'h6c + i;
            a0 = 16'h0040 + ((i % 2) ? 16'd512 : 16'd8);
            a1 = 16'h0040 + ((i % 2) ? 16'd1536 : 16'd24);
            i_lane.issue(8'h4d, a0, 8'h00, 8'h00, 64'ha0 + i, 64'h0);
            i_lane.issue(8'h4d, a1, 8'h00, 8'h00, 64'hb0 + i, 64'h0);
            i_lane.issue(c, 16'h0040, 8'h01, 8'h03, 64'hc0 + i, 64'hd0 + i);
            chk("old first", 64'ha0 + i, i_lane.got0);
            chk("old second", 64'hb0 + i, i_lane.got1);
            peek(a0, 64'hc0 + i);
            peek(a1, 64'hd0 + i);
        end
        $display("test dual ops done");
    endtask
    task end_sim;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #800000;
        failures++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge clock_in);
        #1 rstn_in = 1'b1;
        t_alu;
        t_dual;
        atom(8'h51, 64'h0, 64'h8000000000000000, 64'h12, 64'h12);
        atom(8'h51, 64'h7ff8000000000000, 64'h7ff8000000000000, 64'h12,
             64'h7ff8000000000000);
        atom(8'h52, 64'h4000000000000000, 64'h3ff0000000000000, 64'h0,
             64'h3ff0000000000000);
        atom(8'h52, 64'h4000000000000000, 64'h7ff8000000000000, 64'h0,
             64'h4000000000000000);
        atom(8'h53, 64'h3ff0000000000000, 64'hfff0000000000000, 64'h0,
             64'h3ff0000000000000);
        atom(8'h55, 64'h3f8000005555aaaa, 64'h40000000, 64'h0,
             64'h404000005555aaaa);
        // Low half of the qword, exact zero sum
        i_lane.issue(8'h4d, 16'h0100, 8'h00, 8'h00, 64'h123456783f800000, 0);
        i_lane.issue(8'h55, 16'h0100, 8'h00, 8'h00, 64'hbf800000, 64'h0);
        chk("f32 low old", 64'h3f800000, i_lane.got0);
        peek(16'h0100, 64'h1234567800000000);
        atom(8'h54, 64'h77, 64'h1, 64'h2, 64'h77);
        atom(8'h71, 64'h66, 64'h1, 64'h2, 64'h66);
        $display("test float and error ops done");
        end_sim;
    end
endmodule
`default_nettype wire
